//--- logic/flash_host_cfg.svh
// Offsets, command codes, status bit positions and timing counts of the flash host controller
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// Word indices on the register bus; byte address is four times the index
`define CTRL_IDX          3'h0
`define ADDR_IDX          3'h1
`define WDATA_IDX         3'h2
`define STATUS_IDX        3'h3
`define REG_COUNT         3'h4

// Status register fields
`define ST_BUSY_POS       0
`define ST_DONE_POS       1
`define ST_FAIL_POS       2
`define ST_REFUSED_POS    3
`define ST_WINDOW_POS     4
`define ST_READY_POS      5
`define ST_RDATA_LSB      8

// Command set
`define UNLOCK1_ADDR      20'haaa
`define UNLOCK1_DATA      8'haa
`define UNLOCK2_ADDR      20'h555
`define UNLOCK2_DATA      8'h55
`define CMD_ERASE_SETUP   8'h80
`define CMD_CHIP_ERASE    8'h10
`define CMD_SECTOR_ERASE  8'h30
`define CMD_SUSPEND       8'hb0
`define CMD_RESUME        8'h30
`define CMD_PROGRAM       8'ha0
`define CMD_ID_READ       8'h90
`define CMD_RESET         8'hf0

// Status bits on the data pins
`define POLL_BIT          7
`define TOGGLE_BIT        6
`define TIMEOUT_BIT       5

// Timing
`define CNT_W             11
`define CLK_NS            40
`define WINDOW_US         50
`define WINDOW_CYC        ((`WINDOW_US * 1000) / `CLK_NS)
`define WE_LOW_NS         45
`define WE_LOW_CYC        ((`WE_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define RD_ACC_NS         90
`define RD_ACC_CYC        ((`RD_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define SYNC_CYC          2
`define RST_PULSE_NS      500
`define RST_PULSE_CYC     ((`RST_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define WIN_MARGIN        3

`endif

//--- logic/flash_host_ctrl.sv
// Wishbone-controlled host that drives command sequences into a parallel flash
// How it works
// RL1 - Erase: unlock, unlock, 80, unlock, unlock, 10/30
// RL2 - Device pre-programs and erases on its own
// RL3 - Device sets timeout bit on erase overrun
// RL4 - Erase done when toggle steady twice
// RL5 - Array reads need no command
// RL6 - Suspended sectors read status, others array
// RL7 - Reset command returns to array, address ignored
// RL8 - Reset aborts erase sequence, ignored once erasing
// RL9 - Reset aborts program sequence, ignored once programming
// RL10 - Host leaves identification mode with reset command
// RL11 - Host writes reset after timeout bit rises
// RL12 - Device latches sector address and data edges
// RL13 - Next sector load within 50us window
// RL14 - Other writes during window return to read
// RL15 - Suspend only acts during sector erase
// RL16 - Suspend within 20us, or at once in window
// RL17 - Suspended device accepts resume, program, reads only
// RL18 - Resume only acts after accepted suspend
// RL19 - Program: unlock, unlock, setup, address with data
// RL20 - Device ignores writes while programming
// RL21 - Programming only clears bits
// RL22 - Reset code aborts failed operation
// RL23 - Identification reads: maker at 0, part at 1
// RL24 - Poll bit complements data while programming
// RL25 - Toggle bit inverts each read while busy
// RL26 - Customary unlock and command patterns
// RL27 - Mismatched write returns decoder to read
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_host_ctrl #(
  parameter int WINDOW_CYCLES = `WINDOW_CYC
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic [31:0]                 adr_i,
  input  wire logic [31:0]                 dat_i,
  input  wire logic [3:0]                  sel_i,
  input  wire logic                        we_i,
  input  wire logic                        cyc_i,
  input  wire logic                        stb_i,
  output logic      [31:0]                 dat_o,
  output logic                             ack_o,
  output flash_host_pkg::flash_pins_s      pins,
  input  wire logic [7:0]                  dq_in,
  input  wire logic                        ready_busy_n
);
  flash_host_pkg::state_e     state_reg;
  flash_host_pkg::op_e        op_reg;
  flash_host_pkg::bus_cycle_s cyc_now;
  logic [2:0]         step_reg;
  logic [`CNT_W-1:0]  cnt_reg;
  logic [`CNT_W-1:0]  win_reg;
  logic [19:0]        addr_reg;
  logic [7:0]         wdata_reg;
  logic [7:0]         rdata_reg;
  logic [7:0]         prev_reg;
  logic               have_prev_reg;
  logic               to_seen_reg;
  logic               force_rst_reg;
  logic               done_reg;
  logic               fail_reg;
  logic               refused_reg;
  logic [8:0]         pin_sync_out;

  pin_sync #(.WIDTH(9)) u_pin_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in ({ready_busy_n, dq_in}),
    .sync_out (pin_sync_out)
  );

  // Bus decode
  wire        wb_acc     = cyc_i & stb_i & ~ack_o;
  wire [2:0]  wb_idx     = adr_i[4:2];
  wire        wb_mapped  = (adr_i[31:5] == 27'h0) && (wb_idx < `REG_COUNT);
  wire        wb_wr      = wb_acc & we_i & wb_mapped;
  wire        ctrl_wr    = wb_wr && (wb_idx == `CTRL_IDX) && sel_i[0];
  wire        idle       = (state_reg == flash_host_pkg::ST_IDLE);
  wire [3:0]  req_code   = dat_i[3:0];
  wire        req_valid  = (req_code <= 4'(flash_host_pkg::OP_HW_RESET));
  wire        req_add    = (req_code == 4'(flash_host_pkg::OP_SECTOR_ADD));
  wire        win_open   = (win_reg != '0);
  wire        add_late   = req_add && (win_reg <= `CNT_W'(`WIN_MARGIN));
  wire        start      = ctrl_wr && idle && req_valid && !add_late;
  wire        refuse     = ctrl_wr && !start;
  wire [31:0] addr_merge = {sel_i[3] ? dat_i[31:24] : 8'h00,
                            sel_i[2] ? dat_i[23:16] : {4'h0, addr_reg[19:16]},
                            sel_i[1] ? dat_i[15:8]  : addr_reg[15:8],
                            sel_i[0] ? dat_i[7:0]   : addr_reg[7:0]};
  wire [31:0] status_word = {16'h0, rdata_reg, 2'b00, pin_sync_out[8], win_open,
                             refused_reg, fail_reg, done_reg, !idle};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= wb_acc;
      dat_o <= (wb_acc && !we_i && wb_mapped && wb_idx == `STATUS_IDX) ? status_word :
               (wb_acc && !we_i && wb_mapped && wb_idx == `ADDR_IDX) ? {12'h000, addr_reg} :
               (wb_acc && !we_i && wb_mapped && wb_idx == `WDATA_IDX) ? {24'h0, wdata_reg} : 32'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addr_reg  <= 20'h00000;
      wdata_reg <= 8'h00;
    end else if (wb_wr && idle) begin
      if (wb_idx == `ADDR_IDX)
        addr_reg <= addr_merge[19:0];
      if (wb_idx == `WDATA_IDX && sel_i[0])
        wdata_reg <= dat_i[7:0];
    end
  end

  // Command sequence table; the customary unlock pattern  [RL26]
  function automatic flash_host_pkg::bus_cycle_s seq_cycle(
    input flash_host_pkg::op_e op, input logic [2:0] step, input logic [19:0] ua, input logic [7:0] ud);
    flash_host_pkg::bus_cycle_s c;
    c = '{addr: ua, data: `CMD_RESET};
    case (op)
      flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_CHIP_ERASE,
      flash_host_pkg::OP_SECTOR_ERASE, flash_host_pkg::OP_ID_READ: begin
        case (step)
          3'h0, 3'h3: c = '{addr: `UNLOCK1_ADDR, data: `UNLOCK1_DATA};
          3'h1, 3'h4: c = '{addr: `UNLOCK2_ADDR, data: `UNLOCK2_DATA};
          default: c = '{addr: `UNLOCK1_ADDR, data: `CMD_CHIP_ERASE};
        endcase
        if (step == 3'h2)
          c.data = (op == flash_host_pkg::OP_PROGRAM) ? `CMD_PROGRAM :
                   (op == flash_host_pkg::OP_ID_READ) ? `CMD_ID_READ : `CMD_ERASE_SETUP;  // [RL1]
        if (op == flash_host_pkg::OP_PROGRAM && step == 3'h3)
          c = '{addr: ua, data: ud};  // [RL19]
        if (op == flash_host_pkg::OP_SECTOR_ERASE && step == 3'h5)
          c = '{addr: ua, data: `CMD_SECTOR_ERASE};  // [RL1]
      end
      flash_host_pkg::OP_SECTOR_ADD: c.data = `CMD_SECTOR_ERASE;  // [RL13]
      flash_host_pkg::OP_SUSPEND:    c.data = `CMD_SUSPEND;
      flash_host_pkg::OP_RESUME:     c.data = `CMD_RESUME;
      default:                       c.data = `CMD_RESET;
    endcase
    return c;
  endfunction : seq_cycle

  function automatic logic [2:0] last_step(input flash_host_pkg::op_e op);
    case (op)
      flash_host_pkg::OP_PROGRAM:      return 3'h3;
      flash_host_pkg::OP_CHIP_ERASE:   return 3'h5;
      flash_host_pkg::OP_SECTOR_ERASE: return 3'h5;
      flash_host_pkg::OP_ID_READ:      return 3'h2;
      default:                         return 3'h0;
    endcase
  endfunction : last_step

  assign cyc_now = force_rst_reg ? flash_host_pkg::bus_cycle_s'{addr: addr_reg, data: `CMD_RESET}
                                 : seq_cycle(op_reg, step_reg, addr_reg, wdata_reg);
  wire last_wr  = force_rst_reg || (step_reg == last_step(op_reg));
  wire polls    = (op_reg == flash_host_pkg::OP_PROGRAM) || (op_reg == flash_host_pkg::OP_CHIP_ERASE) ||
                  (op_reg == flash_host_pkg::OP_SUSPEND) || (op_reg == flash_host_pkg::OP_POLL);
  wire reads    = polls || (op_reg == flash_host_pkg::OP_ID_READ);
  wire loads    = (op_reg == flash_host_pkg::OP_SECTOR_ERASE) || (op_reg == flash_host_pkg::OP_SECTOR_ADD);
  wire hold_end = (state_reg == flash_host_pkg::ST_HOLD);
  wire win_load = hold_end && last_wr && loads && !force_rst_reg;
  // Other writes close the window on the device; all other commands but suspend clear it here too
  wire win_kill = start && req_code != 4'(flash_host_pkg::OP_SECTOR_ADD)
                        && req_code != 4'(flash_host_pkg::OP_SUSPEND);  // [RL14]
  wire toggled  = (rdata_reg[`TOGGLE_BIT] != prev_reg[`TOGGLE_BIT]);

  // Window counter runs from the rising strobe of the last sector load
  always_ff @(posedge ref_clk) begin
    if (reset || win_kill)
      win_reg <= '0;
    else if (win_load)
      win_reg <= `CNT_W'(WINDOW_CYCLES);  // [RL13]
    else if (win_open)
      win_reg <= win_reg - `CNT_W'(1);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg     <= flash_host_pkg::ST_IDLE;
      op_reg        <= flash_host_pkg::OP_READ;
      step_reg      <= 3'h0;
      cnt_reg       <= '0;
      rdata_reg     <= 8'h00;
      prev_reg      <= 8'h00;
      have_prev_reg <= 1'b0;
      to_seen_reg   <= 1'b0;
      force_rst_reg <= 1'b0;
      done_reg      <= 1'b0;
      fail_reg      <= 1'b0;
      refused_reg   <= 1'b0;
      pins          <= '{rst_n: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe_n: 1'b1,
                         addr: 20'h00000, dq: 8'h00};
    end else begin
      if (refuse)
        refused_reg <= 1'b1;
      case (state_reg)
        flash_host_pkg::ST_IDLE: begin
          pins.rst_n <= 1'b1;
          if (start) begin
            op_reg        <= flash_host_pkg::op_e'(req_code);
            step_reg      <= 3'h0;
            have_prev_reg <= 1'b0;
            to_seen_reg   <= 1'b0;
            force_rst_reg <= 1'b0;
            done_reg      <= 1'b0;
            fail_reg      <= 1'b0;
            refused_reg   <= 1'b0;
            if (req_code == 4'(flash_host_pkg::OP_HW_RESET)) begin
              pins.rst_n <= 1'b0;
              cnt_reg    <= `CNT_W'(`RST_PULSE_CYC - 1);
              state_reg  <= flash_host_pkg::ST_RSTPULSE;
            end else if (req_code == 4'(flash_host_pkg::OP_READ) || req_code == 4'(flash_host_pkg::OP_POLL))
              state_reg <= flash_host_pkg::ST_READ;  // [RL5]
            else
              state_reg <= flash_host_pkg::ST_SETUP;
          end
        end
        flash_host_pkg::ST_SETUP: begin
          pins.addr    <= cyc_now.addr;
          pins.dq      <= cyc_now.data;
          pins.ce_n    <= 1'b0;
          pins.dq_oe_n <= 1'b0;
          pins.oe_n    <= 1'b1;
          cnt_reg      <= `CNT_W'(`WE_LOW_CYC - 1);
          state_reg    <= flash_host_pkg::ST_STROBE;
        end
        flash_host_pkg::ST_STROBE: begin
          pins.we_n <= 1'b0;
          if (!pins.we_n && cnt_reg == '0) begin
            pins.we_n <= 1'b1;
            pins.ce_n <= 1'b1;
            state_reg <= flash_host_pkg::ST_HOLD;
          end else if (!pins.we_n)
            cnt_reg <= cnt_reg - `CNT_W'(1);
        end
        flash_host_pkg::ST_HOLD: begin
          pins.dq_oe_n <= 1'b1;
          step_reg     <= step_reg + 3'h1;
          if (!last_wr)
            state_reg <= flash_host_pkg::ST_SETUP;
          else if (reads && !force_rst_reg)
            state_reg <= flash_host_pkg::ST_READ;
          else begin
            state_reg <= flash_host_pkg::ST_IDLE;
            done_reg  <= 1'b1;
          end
        end
        flash_host_pkg::ST_READ: begin
          pins.addr <= addr_reg;
          pins.ce_n <= 1'b0;
          pins.oe_n <= 1'b0;
          if (pins.oe_n)
            cnt_reg <= `CNT_W'(`RD_ACC_CYC + `SYNC_CYC - 1);
          else if (cnt_reg == '0) begin
            rdata_reg <= pin_sync_out[7:0];
            pins.ce_n <= 1'b1;
            pins.oe_n <= 1'b1;
            state_reg <= flash_host_pkg::ST_CHECK;
          end else
            cnt_reg <= cnt_reg - `CNT_W'(1);
        end
        flash_host_pkg::ST_CHECK: begin
          prev_reg      <= rdata_reg;
          have_prev_reg <= 1'b1;
          state_reg     <= flash_host_pkg::ST_READ;
          if (op_reg == flash_host_pkg::OP_ID_READ) begin
            force_rst_reg <= 1'b1;  // [RL10]
            state_reg     <= flash_host_pkg::ST_SETUP;
          end else if (!polls) begin
            done_reg  <= 1'b1;
            state_reg <= flash_host_pkg::ST_IDLE;
          end else if (have_prev_reg && !toggled) begin
            done_reg  <= 1'b1;  // [RL4]
            state_reg <= flash_host_pkg::ST_IDLE;
          end else if (have_prev_reg && rdata_reg[`TIMEOUT_BIT]) begin
            // Toggle may stop just as the timeout bit rises, so look twice
            if (to_seen_reg) begin
              fail_reg      <= 1'b1;  // [RL11]
              force_rst_reg <= 1'b1;
              state_reg     <= flash_host_pkg::ST_SETUP;
            end else begin
              to_seen_reg   <= 1'b1;
              have_prev_reg <= 1'b0;
            end
          end
        end
        flash_host_pkg::ST_RSTPULSE: begin
          if (cnt_reg == '0) begin
            pins.rst_n <= 1'b1;
            done_reg   <= 1'b1;
            state_reg  <= flash_host_pkg::ST_IDLE;
          end else
            cnt_reg <= cnt_reg - `CNT_W'(1);
        end
        default: state_reg <= flash_host_pkg::ST_IDLE;
      endcase
    end
  end

  a_erase_setup_code: assert property (@(posedge ref_clk) disable iff (reset)  // [RL1]
    (state_reg == flash_host_pkg::ST_SETUP && !force_rst_reg && step_reg == 3'h2 &&
     (op_reg == flash_host_pkg::OP_CHIP_ERASE || op_reg == flash_host_pkg::OP_SECTOR_ERASE))
    |=> (pins.dq == `CMD_ERASE_SETUP && !pins.dq_oe_n && !pins.ce_n))
    else $error("erase set-up code not driven in third write");

  a_chip_erase_last: assert property (@(posedge ref_clk) disable iff (reset)  // [RL1]
    (state_reg == flash_host_pkg::ST_SETUP && !force_rst_reg && step_reg == 3'h5 &&
     op_reg == flash_host_pkg::OP_CHIP_ERASE) |=> ##1 (!pins.we_n && pins.dq == `CMD_CHIP_ERASE))
    else $error("chip erase code missing in sixth write");

  a_we_pulse_width: assert property (@(posedge ref_clk) disable iff (reset)  // [RL19]
    $fell(pins.we_n) |-> ##1 !pins.we_n ##1 (pins.we_n && pins.ce_n))
    else $error("write strobe not two cycles low");

  a_program_data_write: assert property (@(posedge ref_clk) disable iff (reset)  // [RL19]
    (state_reg == flash_host_pkg::ST_SETUP && !force_rst_reg && step_reg == 3'h3 &&
     op_reg == flash_host_pkg::OP_PROGRAM) |=> (pins.dq == wdata_reg && pins.addr == addr_reg))
    else $error("program write lacks target address or data");

  a_id_mode_exit: assert property (@(posedge ref_clk) disable iff (reset)  // [RL10]
    (state_reg == flash_host_pkg::ST_CHECK && op_reg == flash_host_pkg::OP_ID_READ)
    |-> ##[2:6] (!pins.we_n && pins.dq == `CMD_RESET))
    else $error("identification read not closed by reset command");

  a_timeout_reset: assert property (@(posedge ref_clk) disable iff (reset)  // [RL11]
    $rose(fail_reg) |-> ##[2:6] (!pins.we_n && pins.dq == `CMD_RESET))
    else $error("no reset command after timeout failure");

  a_window_late_add: assert property (@(posedge ref_clk) disable iff (reset)  // [RL13]
    (ctrl_wr && idle && req_add && !win_open) |=> (refused_reg && state_reg == flash_host_pkg::ST_IDLE))
    else $error("sector load accepted after window closed");

  a_window_add_start: assert property (@(posedge ref_clk) disable iff (reset)  // [RL13]
    (start && req_add) |-> ##[2:3] (!pins.we_n && win_open))
    else $error("sector load strobe not inside window");

endmodule : flash_host_ctrl
`default_nettype wire

//--- logic/flash_host_pkg.sv
// Types shared by the flash host controller
package flash_host_pkg;

  typedef enum logic [3:0] {
    OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SECTOR_ADD,
    OP_SUSPEND, OP_RESUME, OP_RESET, OP_ID_READ, OP_POLL, OP_HW_RESET
  } op_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_READ, ST_CHECK, ST_RSTPULSE
  } state_e;

  typedef struct packed {
    logic        rst_n;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        dq_oe_n;
    logic [19:0] addr;
    logic [7:0]  dq;
  } flash_pins_s;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  data;
  } bus_cycle_s;

endpackage : flash_host_pkg

//--- logic/pin_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pin_sync
`default_nettype wire

//--- sim/flash_dev_model.sv
// Behavioural byte-wide flash device that answers the host controller
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5b, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h6c, // Arbitrary value
  parameter int         PROG_NS    = 2000,
  parameter int         ERASE_NS   = 4000,
  parameter int         WIN_NS     = 2000
) (
  input  wire logic        rst_n,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             ready_busy_n
);
  logic [7:0]  mem [0:1048575];
  logic [7:0]  pdata;
  logic [7:0]  rbyte = 8'h00;
  logic [19:0] pa;
  logic [15:0] esec  = 16'h0;
  logic        tog   = 1'b0;
  logic        tout  = 1'b0;
  logic        chip  = 1'b0;
  int          step  = 0;
  int          mode  = 0; // 0 array, 1 ident, 2 program, 3 erase, 4 window, 5 suspended
  int          pmode = 0;
  realtime     due   = 0;
  realtime     sdue  = 0;
  realtime     rem   = 0;
  wire         rd    = !ce_n && !oe_n && rst_n;

  initial foreach (mem[i]) mem[i] = 8'hff;

  // Released bus shows the inverse so a stale value never passes
  assign dq_out       = rd ? rbyte : ~rbyte;
  assign ready_busy_n = !(mode == 2 || mode == 3);

  task automatic write_cycle(input logic [19:0] a, input logic [7:0] d);
    if (mode == 2 || mode == 3) begin
      if (tout && d == 8'hf0) begin
        tout = 1'b0;
        mode = pmode;
      end else if (mode == 3 && !chip && d == 8'hb0) sdue = $realtime + 1000;
      return;
    end
    if (d == 8'hf0) begin
      step = 0;
      if (mode != 5) mode = 0;
      return;
    end
    if (mode == 1) return;
    if (mode == 4) begin
      if (d == 8'h30) begin
        esec[a[19:16]] = 1'b1;
        due = $realtime + WIN_NS;
        return;
      end
      if (d == 8'hb0) begin
        rem = ERASE_NS;
        mode = 5;
        return;
      end
      mode = 0;
    end
    if (mode == 5 && step == 0 && d == 8'h30) begin
      due = $realtime + rem;
      mode = 3;
      return;
    end
    case (step)
      0: step = (a == 20'haaa && d == 8'haa) ? 1 : 0;
      1: step = (a == 20'h555 && d == 8'h55) ? 2 : 0;
      2: begin
        step = (a == 20'haaa && d == 8'ha0) ? 6 : (a == 20'haaa && d == 8'h80 && mode == 0) ? 3 : 0;
        if (a == 20'haaa && d == 8'h90 && mode == 0) mode = 1;
      end
      3: step = (a == 20'haaa && d == 8'haa) ? 4 : 0;
      4: step = (a == 20'h555 && d == 8'h55) ? 5 : 0;
      5: begin
        step = 0;
        chip = (d == 8'h10);
        if (d == 8'h10) mode = 3;
        if (d == 8'h30) mode = 4;
        if (d == 8'h30) esec[a[19:16]] = 1'b1;
        due = $realtime + (chip ? ERASE_NS : WIN_NS);
      end
      default: begin
        step = 0;
        if (mode == 0 || !esec[a[19:16]]) begin
          pa = a;
          pdata = d;
          pmode = mode;
          tout = |(d & ~mem[a]);
          mode = 2;
          due = $realtime + PROG_NS;
        end
      end
    endcase
  endtask : write_cycle

  // Host lifts both strobes together, so take data on whichever rises first
  wire         wr_low = !ce_n && !we_n;
  always @(negedge wr_low) if (rst_n) write_cycle(addr, dq_in);

  always @(posedge rd) begin
    if (mode == 2 || mode == 3) begin
      tog = ~tog;
      rbyte = {mode == 2 ? ~pdata[7] : 1'b0, tog, tout, 5'h00};
    end else if (mode == 1) rbyte = (addr[1:0] == 2'h0) ? MAKER_CODE : PART_CODE;
    else if ((mode == 4 || mode == 5) && esec[addr[19:16]]) rbyte = 8'h80;
    else rbyte = mem[addr];
  end

  always #20 begin
    if (mode == 2 && !tout && $realtime >= due) begin
      mem[pa] = mem[pa] & pdata;
      mode = pmode;
    end
    if (mode == 4 && $realtime >= due) begin
      mode = 3;
      due = $realtime + ERASE_NS;
    end
    if (mode == 3 && sdue > 0 && $realtime >= sdue) begin
      rem = due - $realtime;
      sdue = 0;
      mode = 5;
    end
    if (mode == 3 && $realtime >= due) begin
      foreach (mem[i]) if (chip || esec[i[19:16]]) mem[i] = 8'hff;
      esec = 16'h0;
      mode = 0;
    end
  end

  always @(negedge rst_n) begin
    mode = 0;
    step = 0;
    tout = 1'b0;
    esec = 16'h0;
    sdue = 0;
  end
endmodule : flash_dev_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the flash host controller against a device model
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module tb_top;
  logic                        ref_clk = 1'b0;
  logic                        reset   = 1'b1;
  logic                        we_i    = 1'b0;
  logic                        cyc_i   = 1'b0;
  logic                        stb_i   = 1'b0;
  logic [31:0]                 adr_i   = 32'h0;
  logic [31:0]                 dat_i   = 32'h0;
  logic [3:0]                  sel_i   = 4'h0;
  logic [31:0]                 dat_o;
  logic                        ack_o;
  logic                        rb_n;
  logic [7:0]                  dev_dq;
  wire  [7:0]                  dq_wire;
  flash_host_pkg::flash_pins_s pins;
  int                          error_cnt = 0;
  int                          compares  = 0;
  int                          cyc_cnt   = 0;

  always #20 ref_clk = ~ref_clk;
  assign dq_wire = pins.dq_oe_n ? dev_dq : pins.dq;

  flash_host_ctrl #(.WINDOW_CYCLES(40)) i_flash_host_ctrl (
    .ref_clk(ref_clk), .reset(reset), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .pins(pins), .dq_in(dq_wire),
    .ready_busy_n(rb_n));

  flash_dev_model i_flash_dev_model (
    .rst_n(pins.rst_n), .ce_n(pins.ce_n), .we_n(pins.we_n), .oe_n(pins.oe_n), .addr(pins.addr),
    .dq_in(dq_wire), .dq_out(dev_dq), .ready_busy_n(rb_n));

  task automatic stop_test;
    $display("errors %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    adr_i <= a;
    we_i  <= w;
    dat_i <= d;
    sel_i <= 4'hf;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do
      @(posedge ref_clk);
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb

  // Busy is polled with a bound so a stuck operation cannot hang the run
  task automatic run_op(input flash_host_pkg::op_e op, input logic [19:0] a, input logic [7:0] d,
                        output logic [31:0] s);
    logic [31:0] q;
    int          n;
    n = 0;
    wb(32'h4, 1'b1, {12'h0, a}, q);
    wb(32'h8, 1'b1, {24'h0, d}, q);
    wb(32'h0, 1'b1, {28'h0, op}, q);
    do begin
      wb(32'hc, 1'b0, 32'h0, s);
      n++;
    end while (s[`ST_BUSY_POS] !== 1'b0 && n < 500);
    if (n >= 500) error_cnt++;
  endtask : run_op

  task automatic rd_chk(input string name, input logic [19:0] a, input logic [7:0] exp);
    logic [31:0] s;
    run_op(flash_host_pkg::OP_READ, a, 8'h00, s);
    check(name, {24'h0, exp}, {24'h0, s[15:8]});
  endtask : rd_chk

  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      error_cnt++;
      stop_test;
    end
  end

  initial begin
    logic [31:0] s;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    wb(32'hc, 1'b0, 32'h0, s);
    check("status after reset", 32'h20, s);
    check("idle pins", 32'h1f, {27'h0, pins.rst_n, pins.ce_n, pins.we_n, pins.oe_n, pins.dq_oe_n});
    rd_chk("erased byte", 20'h10000, 8'hff);
    run_op(flash_host_pkg::OP_PROGRAM, 20'h10000, 8'h11, s);
    check("program flags", 32'h2, {29'h0, s[2:0]});
    run_op(flash_host_pkg::OP_PROGRAM, 20'h30000, 8'h3c, s);
    rd_chk("programmed byte", 20'h10000, 8'h11);
    run_op(flash_host_pkg::OP_PROGRAM, 20'h10000, 8'hff, s);
    check("fail on raising bits", 32'h1, {31'h0, s[`ST_FAIL_POS]});
    rd_chk("cell kept after fail", 20'h10000, 8'h11);
    run_op(flash_host_pkg::OP_ID_READ, 20'h00000, 8'h00, s);
    check("maker code", 32'h5b, {24'h0, s[15:8]});
    run_op(flash_host_pkg::OP_ID_READ, 20'h00001, 8'h00, s);
    check("part code", 32'h6c, {24'h0, s[15:8]});
    rd_chk("array after ident", 20'h10000, 8'h11);
    run_op(flash_host_pkg::OP_SECTOR_ERASE, 20'h10000, 8'h00, s);
    check("window open", 32'h1, {31'h0, s[`ST_WINDOW_POS]});
    run_op(flash_host_pkg::OP_SECTOR_ADD, 20'h50000, 8'h00, s);
    check("window after load", 32'h1, {31'h0, s[`ST_WINDOW_POS]});
    run_op(flash_host_pkg::OP_SUSPEND, 20'h10000, 8'h00, s);
    rd_chk("other sector in suspend", 20'h30000, 8'h3c);
    rd_chk("suspended sector status", 20'h10000, 8'h80);
    run_op(flash_host_pkg::OP_PROGRAM, 20'h20000, 8'h22, s);
    rd_chk("program in suspend", 20'h20000, 8'h22);
    rd_chk("status after suspend program", 20'h10000, 8'h80);
    run_op(flash_host_pkg::OP_RESUME, 20'h10000, 8'h00, s);
    run_op(flash_host_pkg::OP_POLL, 20'h10000, 8'h00, s);
    rd_chk("sector erased", 20'h10000, 8'hff);
    rd_chk("sector kept", 20'h30000, 8'h3c);
    run_op(flash_host_pkg::OP_SECTOR_ADD, 20'h50000, 8'h00, s);
    check("late sector load refused", 32'h1, {31'h0, s[`ST_REFUSED_POS]});
    run_op(flash_host_pkg::OP_CHIP_ERASE, 20'h00000, 8'h00, s);
    rd_chk("chip erased", 20'h30000, 8'hff);
    run_op(flash_host_pkg::OP_RESUME, 20'h30000, 8'h00, s);
    rd_chk("resume without suspend", 20'h20000, 8'hff);
    run_op(flash_host_pkg::OP_RESET, 20'h12345, 8'h00, s);
    rd_chk("array after reset", 20'h20000, 8'hff);
    wb(32'h0, 1'b1, 32'hf, s);
    wb(32'hc, 1'b0, 32'h0, s);
    check("invalid op refused", 32'h1, {31'h0, s[`ST_REFUSED_POS]});
    wb(32'h40, 1'b0, 32'h0, s);
    check("unmapped read", 32'h0, s);
    run_op(flash_host_pkg::OP_HW_RESET, 20'h00000, 8'h00, s);
    check("hardware reset done", 32'h2, {29'h0, s[2:0]});
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
